// file: logic/dpc_pkg.sv
// constants and types of the converter pll configuration and status block
package dpc_pkg;
    // register offsets on the serial control port
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h01F;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h023;
    localparam logic [11:0] ADDR_PLL_CONTROL = 12'h083;
    localparam logic [11:0] ADDR_PLL_STATE_FLAGS = 12'h084;
    localparam logic [11:0] ADDR_FEEDBACK_DIVIDER = 12'h085;
    localparam logic [11:0] ADDR_VCO_OUTPUT_DIVIDER = 12'h08B;
    localparam logic [11:0] ADDR_REFERENCE_DIVIDER = 12'h08C;
    localparam logic [11:0] ADDR_VCO_CAL_OFFSET = 12'h1B4;
    localparam logic [11:0] ADDR_VCO_VARACTOR_SETTING = 12'h1B6;
    localparam logic [11:0] ADDR_VCO_BIAS_SETTING = 12'h1BB;

    // field positions
    localparam int CTRL_ENABLE_BIT = 4;
    localparam int CTRL_RECAL_BIT = 7;
    localparam int STAT_UPPER_EDGE_HI = 7;
    localparam int STAT_UPPER_EDGE_LO = 6;
    localparam int STAT_CAL_DONE_BIT = 5;
    localparam int STAT_BAND_DONE_BIT = 3;
    localparam int STAT_LOWER_EDGE_BIT = 2;
    localparam int STAT_LOCK_BIT = 1;
    localparam int IRQ_LOCK_BIT = 5;
    localparam int IRQ_LOST_BIT = 4;
    localparam int VCO_DIV_CODE_W = 2;
    localparam int REF_DIV_CODE_W = 3;

    // values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_VCO_DIV_CODE = 2'h0;
    localparam logic [2:0] RST_REF_DIV_CODE = 3'h0;

    // vco band search
    localparam int BAND_W = 9;
    localparam logic [8:0] BAND_FIRST = 9'h000;
    localparam logic [8:0] BAND_LAST = 9'h1FF; // 512 bands
    localparam int CLOCK_PERIOD_NS = 25;
    localparam int BAND_SETTLE_NS = 100;
    localparam int BAND_SETTLE_CYC_INT = (BAND_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [7:0] BAND_SETTLE_CYC = 8'(BAND_SETTLE_CYC_INT);

    typedef enum logic [1:0] {
        BAND_IDLE = 2'b00,
        BAND_SEARCH = 2'b01,
        BAND_SETTLE = 2'b10,
        BAND_TRACK = 2'b11
    } dpc_band_state_t;
endpackage

// file: logic/dpc_pll_ctrl.sv
// pll configuration registers, band selection, status flags and lock events
`timescale 1ns/1ps

// Operation
// - after enable the block searches the 512 vco bands by itself
// - once the search is done, band-edge flags nudge the band without host help
// - vco output divider code sits in bits 1:0 of its register
// - feedback loop divider takes all eight bits of its register
// - reference divider code sits in bits 2:0 of its register
// - state flags bit 5 shows calibration done and valid
// - state flags bit 1 shows pll locked
// - state flags report upper band edge on 7:6 and lower edge
// - lock and lost-lock events gated by enable bits 5 and 4
// - irq status bits 5 and 4 read the events; writing one to a bit clears it
// - output divider codes 1, 2, 3 give division by 4, 8, 16
// - reference code n gives division by two to the n, up to 32
module dpc_pll_ctrl (
    input wire logic clock,
    input wire logic resetn,
    input wire logic softReset,
    input wire logic [11:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdValid,
    input wire logic pllLockRaw,
    input wire logic calDoneRaw,
    input wire logic upperEdgeRaw,
    input wire logic lowerEdgeRaw,
    input wire logic vcoInBandRaw,
    output logic pllEnable,
    output logic pllRecal,
    output logic [dpc_pkg::BAND_W-1:0] vcoBand,
    output logic [7:0] feedbackLoopDivider,
    output logic [1:0] vcoOutputDividerCode,
    output logic [2:0] referenceDividerCode,
    output logic [4:0] vcoOutputDivisionFactor,
    output logic [5:0] referenceDivisionFactor,
    output logic [7:0] vcoCalOffset,
    output logic [7:0] vcoVaractorSetting,
    output logic [7:0] vcoBiasSetting,
    output logic pllIrq
);
    import dpc_pkg::*;

    logic [7:0] irqEnable_r;
    logic [7:0] control_r;
    logic [7:0] feedback_r;
    logic [1:0] vcoDivCode_r;
    logic [2:0] refDivCode_r;
    logic [7:0] calOffset_r;
    logic [7:0] varactor_r;
    logic [7:0] bias_r;
    logic irqLock_r;
    logic irqLost_r;
    logic [4:0] syncA_r;
    logic [4:0] syncB_r;
    logic lockPrev_r;
    logic recalPrev_r;
    dpc_band_state_t bandState_r;
    logic [BAND_W-1:0] band_r;
    logic [7:0] settleCnt_r;
    logic tracking_r;
    logic bandDone_r;
    logic lockSync;
    logic calSync;
    logic upperSync;
    logic lowerSync;
    logic inBandSync;
    logic lockRise;
    logic lockFall;
    logic recalRise;
    logic wrIrqStatus;
    logic [7:0] readMux;

    // vco output division factor from its code, zero for the unused code
    function automatic logic [4:0] vcoFactor(input logic [1:0] code);
        case (code)
            2'h1: vcoFactor = 5'h04;
            2'h2: vcoFactor = 5'h08;
            2'h3: vcoFactor = 5'h10;
            default: vcoFactor = 5'h00;
        endcase
    endfunction

    // reference division factor, powers of two up to 32, zero above
    function automatic logic [5:0] refFactor(input logic [2:0] code);
        if (code <= 3'h5) begin
            refFactor = 6'(6'h01 << code);
        end else begin
            refFactor = 6'h00;
        end
    endfunction

    // two-stage synchronisers for analog indications
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            syncA_r <= 5'h00;
            syncB_r <= 5'h00;
        end else begin
            syncA_r <= {vcoInBandRaw, lowerEdgeRaw, upperEdgeRaw, calDoneRaw, pllLockRaw};
            syncB_r <= syncA_r;
        end
    end

    assign lockSync = syncB_r[0];
    assign calSync = syncB_r[1];
    assign upperSync = syncB_r[2];
    assign lowerSync = syncB_r[3];
    assign inBandSync = syncB_r[4];

    // configuration register writes
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irqEnable_r <= RST_BYTE;
            control_r <= RST_BYTE;
            feedback_r <= RST_BYTE;
            vcoDivCode_r <= RST_VCO_DIV_CODE;
            refDivCode_r <= RST_REF_DIV_CODE;
            calOffset_r <= RST_BYTE;
            varactor_r <= RST_BYTE;
            bias_r <= RST_BYTE;
        end else if (softReset) begin
            irqEnable_r <= RST_BYTE;
            control_r <= RST_BYTE;
            feedback_r <= RST_BYTE;
            vcoDivCode_r <= RST_VCO_DIV_CODE;
            refDivCode_r <= RST_REF_DIV_CODE;
            calOffset_r <= RST_BYTE;
            varactor_r <= RST_BYTE;
            bias_r <= RST_BYTE;
        end else if (regWrEn) begin
            case (regAddr)
                ADDR_IRQ_ENABLE: irqEnable_r <= regWrData;
                ADDR_PLL_CONTROL: control_r <= regWrData;
                ADDR_FEEDBACK_DIVIDER: feedback_r <= regWrData;
                ADDR_VCO_OUTPUT_DIVIDER: vcoDivCode_r <= regWrData[VCO_DIV_CODE_W-1:0];
                ADDR_REFERENCE_DIVIDER: refDivCode_r <= regWrData[REF_DIV_CODE_W-1:0];
                ADDR_VCO_CAL_OFFSET: calOffset_r <= regWrData;
                ADDR_VCO_VARACTOR_SETTING: varactor_r <= regWrData;
                ADDR_VCO_BIAS_SETTING: bias_r <= regWrData;
                default: ;
            endcase
        end
    end

    // configuration outputs and decoded division factors
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pllEnable <= 1'b0;
            pllRecal <= 1'b0;
            feedbackLoopDivider <= RST_BYTE;
            vcoOutputDividerCode <= RST_VCO_DIV_CODE;
            referenceDividerCode <= RST_REF_DIV_CODE;
            vcoOutputDivisionFactor <= 5'h00;
            referenceDivisionFactor <= 6'h00;
            vcoCalOffset <= RST_BYTE;
            vcoVaractorSetting <= RST_BYTE;
            vcoBiasSetting <= RST_BYTE;
        end else begin
            pllEnable <= control_r[CTRL_ENABLE_BIT];
            pllRecal <= control_r[CTRL_RECAL_BIT];
            feedbackLoopDivider <= feedback_r;
            vcoOutputDividerCode <= vcoDivCode_r;
            referenceDividerCode <= refDivCode_r;
            vcoOutputDivisionFactor <= vcoFactor(vcoDivCode_r);
            referenceDivisionFactor <= refFactor(refDivCode_r);
            vcoCalOffset <= calOffset_r;
            vcoVaractorSetting <= varactor_r;
            vcoBiasSetting <= bias_r;
        end
    end

    // edge detection on synchronised lock and on the recalibrate bit
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lockPrev_r <= 1'b0;
            recalPrev_r <= 1'b0;
        end else begin
            lockPrev_r <= lockSync;
            recalPrev_r <= control_r[CTRL_RECAL_BIT];
        end
    end

    assign lockRise = lockSync && !lockPrev_r;
    assign lockFall = !lockSync && lockPrev_r;
    assign recalRise = control_r[CTRL_RECAL_BIT] && !recalPrev_r;

    // automatic vco band search, then temperature tracking while enabled
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bandState_r <= BAND_IDLE;
            band_r <= BAND_FIRST;
            settleCnt_r <= 8'h00;
            tracking_r <= 1'b0;
            bandDone_r <= 1'b0;
        end else if (softReset || !control_r[CTRL_ENABLE_BIT]) begin
            bandState_r <= BAND_IDLE;
            band_r <= BAND_FIRST;
            settleCnt_r <= 8'h00;
            tracking_r <= 1'b0;
            bandDone_r <= 1'b0;
        end else if (recalRise) begin
            bandState_r <= BAND_SEARCH; // restart search on recalibrate
            bandDone_r <= 1'b0;
            tracking_r <= 1'b0;
        end else begin
            case (bandState_r)
                BAND_IDLE: begin
                    bandState_r <= BAND_SEARCH;
                end
                BAND_SEARCH: begin
                    band_r <= BAND_FIRST;
                    settleCnt_r <= BAND_SETTLE_CYC;
                    tracking_r <= 1'b0;
                    bandState_r <= BAND_SETTLE;
                end
                BAND_SETTLE: begin
                    if (settleCnt_r > 8'h01) begin
                        settleCnt_r <= settleCnt_r - 8'h01;
                    end else if (tracking_r || inBandSync || band_r == BAND_LAST) begin
                        bandDone_r <= 1'b1;
                        bandState_r <= BAND_TRACK;
                    end else begin
                        band_r <= band_r + 9'h001;
                        settleCnt_r <= BAND_SETTLE_CYC;
                    end
                end
                BAND_TRACK: begin
                    if (upperSync && band_r != BAND_LAST) begin
                        band_r <= band_r + 9'h001;
                        settleCnt_r <= BAND_SETTLE_CYC;
                        tracking_r <= 1'b1;
                        bandState_r <= BAND_SETTLE;
                    end else if (lowerSync && band_r != BAND_FIRST) begin
                        band_r <= band_r - 9'h001;
                        settleCnt_r <= BAND_SETTLE_CYC;
                        tracking_r <= 1'b1;
                        bandState_r <= BAND_SETTLE;
                    end
                end
                default: bandState_r <= BAND_IDLE;
            endcase
        end
    end

    // band index to the vco
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            vcoBand <= BAND_FIRST;
        end else begin
            vcoBand <= band_r;
        end
    end

    assign wrIrqStatus = regWrEn && (regAddr == ADDR_IRQ_STATUS);

    // sticky lock events; a new event wins over a clear in the same cycle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irqLock_r <= 1'b0;
            irqLost_r <= 1'b0;
        end else if (softReset) begin
            irqLock_r <= 1'b0;
            irqLost_r <= 1'b0;
        end else begin
            if (lockRise && irqEnable_r[IRQ_LOCK_BIT]) begin
                irqLock_r <= 1'b1;
            end else if (wrIrqStatus && regWrData[IRQ_LOCK_BIT]) begin
                irqLock_r <= 1'b0;
            end
            if (lockFall && irqEnable_r[IRQ_LOST_BIT]) begin
                irqLost_r <= 1'b1;
            end else if (wrIrqStatus && regWrData[IRQ_LOST_BIT]) begin
                irqLost_r <= 1'b0;
            end
        end
    end

    // interrupt line follows any pending event
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pllIrq <= 1'b0;
        end else begin
            pllIrq <= irqLock_r || irqLost_r;
        end
    end

    // read data selection; reserved bits and unmapped addresses read zero
    always_comb begin
        readMux = 8'h00;
        case (regAddr)
            ADDR_IRQ_ENABLE: readMux = irqEnable_r;
            ADDR_IRQ_STATUS: begin
                readMux[IRQ_LOCK_BIT] = irqLock_r;
                readMux[IRQ_LOST_BIT] = irqLost_r;
            end
            ADDR_PLL_CONTROL: readMux = control_r;
            ADDR_PLL_STATE_FLAGS: begin
                readMux[STAT_UPPER_EDGE_HI] = upperSync;
                readMux[STAT_UPPER_EDGE_LO] = upperSync;
                readMux[STAT_CAL_DONE_BIT] = calSync;
                readMux[STAT_BAND_DONE_BIT] = bandDone_r;
                readMux[STAT_LOWER_EDGE_BIT] = lowerSync;
                readMux[STAT_LOCK_BIT] = lockSync;
            end
            ADDR_FEEDBACK_DIVIDER: readMux = feedback_r;
            ADDR_VCO_OUTPUT_DIVIDER: readMux[VCO_DIV_CODE_W-1:0] = vcoDivCode_r;
            ADDR_REFERENCE_DIVIDER: readMux[REF_DIV_CODE_W-1:0] = refDivCode_r;
            ADDR_VCO_CAL_OFFSET: readMux = calOffset_r;
            ADDR_VCO_VARACTOR_SETTING: readMux = varactor_r;
            ADDR_VCO_BIAS_SETTING: readMux = bias_r;
            default: readMux = 8'h00;
        endcase
    end

    // registered read answer, one cycle after the read strobe
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            regRdData <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                regRdData <= readMux;
            end
        end
    end
endmodule

// file: test/dpc_pll_ctrl_sva.sv
// assertion checker for the pll configuration and status block ports
`timescale 1ns/1ps
module dpc_pll_ctrl_sva
    import dpc_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic softReset,
    input wire logic [11:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    input wire logic pllLockRaw,
    input wire logic calDoneRaw,
    input wire logic pllEnable,
    input wire logic [7:0] feedbackLoopDivider,
    input wire logic [1:0] vcoOutputDividerCode,
    input wire logic [2:0] referenceDividerCode,
    input wire logic [4:0] vcoOutputDivisionFactor,
    input wire logic [5:0] referenceDivisionFactor,
    input wire logic pllIrq
);
    logic lockEn_r;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn || softReset);
    // lock event enable as last written by the host
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lockEn_r <= 1'b0;
        end else if (softReset) begin
            lockEn_r <= 1'b0;
        end else if (regWrEn && regAddr == ADDR_IRQ_ENABLE) begin
            lockEn_r <= regWrData[IRQ_LOCK_BIT];
        end
    end
    AST_LOCK_FLAG: assert property (
        pllLockRaw [*4] ##0 (regRdEn && regAddr == ADDR_PLL_STATE_FLAGS)
        |=> regRdValid && regRdData[STAT_LOCK_BIT]) else $error("lock flag not set");
    AST_UNLOCK_FLAG: assert property (
        !pllLockRaw [*4] ##0 (regRdEn && regAddr == ADDR_PLL_STATE_FLAGS)
        |=> !regRdData[STAT_LOCK_BIT]) else $error("lock flag stuck high");
    AST_CAL_FLAG: assert property (
        calDoneRaw [*4] ##0 (regRdEn && regAddr == ADDR_PLL_STATE_FLAGS)
        |=> regRdData[STAT_CAL_DONE_BIT]) else $error("cal done flag not set");
    AST_ENABLE_COPY: assert property (regWrEn && regAddr == ADDR_PLL_CONTROL
        |=> ##1 pllEnable == $past(regWrData[CTRL_ENABLE_BIT], 2)) else $error("enable wrong");
    AST_FB_COPY: assert property (regWrEn && regAddr == ADDR_FEEDBACK_DIVIDER
        |=> ##1 feedbackLoopDivider == $past(regWrData, 2)) else $error("feedback wrong");
    AST_VCO_CODE: assert property (regWrEn && regAddr == ADDR_VCO_OUTPUT_DIVIDER
        |=> ##1 vcoOutputDividerCode == $past(regWrData[1:0], 2)) else $error("vco code");
    AST_REF_CODE: assert property (regWrEn && regAddr == ADDR_REFERENCE_DIVIDER
        |=> ##1 referenceDividerCode == $past(regWrData[2:0], 2)) else $error("ref code");
    AST_VCO_FACTOR: assert property (vcoOutputDivisionFactor == (
        (vcoOutputDividerCode == 2'h0) ? 5'h00 : (5'h02 << vcoOutputDividerCode)))
        else $error("vco factor wrong");
    AST_REF_FACTOR: assert property ($changed(referenceDividerCode) |->
        referenceDivisionFactor == ((referenceDividerCode > 3'h5) ? 6'h00 :
        (6'h01 << referenceDividerCode))) else $error("ref factor wrong");
    AST_IRQ_LOCK: assert property (!pllLockRaw [*3] ##1 pllLockRaw [*6] ##0 lockEn_r
        |-> pllIrq) else $error("lock event missing");
    AST_IRQ_CLEAR: assert property ($stable(pllLockRaw) [*5] ##0 (regWrEn &&
        regAddr == ADDR_IRQ_STATUS && regWrData[5:4] == 2'b11) |=> ##1 !pllIrq)
        else $error("irq not cleared");
endmodule

bind dpc_pll_ctrl dpc_pll_ctrl_sva sva (.clock, .resetn, .softReset, .regAddr, .regWrData,
    .regWrEn, .regRdEn, .regRdData, .regRdValid, .pllLockRaw, .calDoneRaw, .pllEnable,
    .feedbackLoopDivider, .vcoOutputDividerCode, .referenceDividerCode,
    .vcoOutputDivisionFactor, .referenceDivisionFactor, .pllIrq);

// file: test/test_dac_pll_config_status.sv
// self-checking bench for the pll configuration and status block
`timescale 1ns/1ps
module test_dac_pll_config_status;
    import dpc_pkg::*;
    logic clock, resetn, softReset, regWrEn, regRdEn, regRdValid, pllEnable, pllRecal, pllIrq;
    logic pllLockRaw, calDoneRaw, upperEdgeRaw, lowerEdgeRaw, vcoInBandRaw, done;
    logic [11:0] regAddr;
    logic [7:0] regWrData, regRdData, feedbackLoopDivider, vcoCalOffset, vcoVaractorSetting;
    logic [7:0] vcoBiasSetting, d;
    logic [BAND_W-1:0] vcoBand, band;
    logic [1:0] vcoOutputDividerCode;
    logic [2:0] referenceDividerCode;
    logic [4:0] vcoOutputDivisionFactor;
    logic [5:0] referenceDivisionFactor;
    int nFail = 0;
    int compares = 0;
    int k;
    logic [11:0] addrs [10] = '{ADDR_IRQ_ENABLE, ADDR_IRQ_STATUS, ADDR_PLL_CONTROL,
        ADDR_PLL_STATE_FLAGS, ADDR_FEEDBACK_DIVIDER, ADDR_VCO_OUTPUT_DIVIDER,
        ADDR_REFERENCE_DIVIDER, ADDR_VCO_CAL_OFFSET, ADDR_VCO_VARACTOR_SETTING,
        ADDR_VCO_BIAS_SETTING};
    logic [7:0] rbk [10] = '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h03, 8'h07, 8'hFF, 8'hFF, 8'hFF};

    dpc_pll_ctrl uut (.clock, .resetn, .softReset, .regAddr, .regWrData, .regWrEn, .regRdEn,
        .regRdData, .regRdValid, .pllLockRaw, .calDoneRaw, .upperEdgeRaw, .lowerEdgeRaw,
        .vcoInBandRaw, .pllEnable, .pllRecal, .vcoBand, .feedbackLoopDivider,
        .vcoOutputDividerCode, .referenceDividerCode, .vcoOutputDivisionFactor,
        .referenceDivisionFactor, .vcoCalOffset, .vcoVaractorSetting, .vcoBiasSetting, .pllIrq);

    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            nFail++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one write strobe, driven from a falling edge; an idle edge follows so that
    // back-to-back calls never lower and raise the strobe in one time step
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        regAddr = a;
        regWrData = v;
        regWrEn = 1'b1;
        @(negedge clock);
        regWrEn = 1'b0;
        @(negedge clock);
    endtask

    // one read strobe; data is valid one cycle later
    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clock);
        regRdEn = 1'b0;
        chk({8'h00, regRdValid}, 9'h001);
        v = regRdData;
        @(negedge clock);
    endtask

    task automatic rc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk({1'b0, v & m}, {1'b0, exp});
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic finalReport;
        $display("comparisons %0d mismatches %0d", compares, nFail);
        if (nFail == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        {resetn, softReset, regWrEn, regRdEn, pllLockRaw, calDoneRaw} = '0;
        {upperEdgeRaw, lowerEdgeRaw, vcoInBandRaw} = '0;
        regAddr = 12'h000;
        regWrData = 8'h00;
        wt(10);
        resetn = 1'b1;
        // reset values, write masks and read-only places
        for (k = 0; k < 10; k++) begin
            rc(addrs[k], 8'hFF, 8'h00);
            wr(addrs[k], 8'hFF);
            rc(addrs[k], 8'hFF, rbk[k]);
            wr(addrs[k], 8'h00);
        end
        rc(12'h000, 8'hFF, 8'h00);
        $display("test registers done");
        // divider code to factor mapping
        for (k = 0; k < 4; k++) begin
            wr(ADDR_VCO_OUTPUT_DIVIDER, 8'(k));
            wt(2);
            chk({4'h0, vcoOutputDivisionFactor}, (k == 0) ? 9'h000 : (9'h002 << k));
        end
        for (k = 0; k < 8; k++) begin
            wr(ADDR_REFERENCE_DIVIDER, 8'(k));
            wt(2);
            chk({3'h0, referenceDivisionFactor}, (k < 6) ? (9'h001 << k) : 9'h000);
        end
        $display("test divider factors done");
        // configuration in documented order, then enable
        wr(ADDR_VCO_OUTPUT_DIVIDER, 8'h02);
        wr(ADDR_FEEDBACK_DIVIDER, 8'h7F);
        wr(ADDR_REFERENCE_DIVIDER, 8'h03);
        wr(ADDR_VCO_CAL_OFFSET, 8'h78);
        wr(ADDR_VCO_VARACTOR_SETTING, 8'h4D);
        wr(ADDR_VCO_BIAS_SETTING, 8'h04);
        wt(2);
        chk({vcoCalOffset, 1'b0}, {8'h78, 1'b0});
        chk({vcoVaractorSetting, 1'b0}, {8'h4D, 1'b0});
        chk({vcoBiasSetting, 1'b0}, {8'h04, 1'b0});
        chk({1'b0, feedbackLoopDivider}, 9'h07F);
        chk({4'h0, vcoOutputDividerCode, referenceDividerCode}, 9'h013);
        wr(ADDR_PLL_CONTROL, 8'h10);
        wt(2);
        chk({8'h00, pllEnable}, 9'h001);
        // band search runs alone until the vco reports in band
        wt(30);
        vcoInBandRaw = 1'b1;
        done = 1'b0;
        for (k = 0; k < 100 && !done; k++) begin
            rd(ADDR_PLL_STATE_FLAGS, d);
            done = d[STAT_BAND_DONE_BIT];
        end
        if (!done) begin
            nFail++;
            finalReport();
        end
        band = vcoBand;
        chk({8'h00, band != 9'h000}, 9'h001);
        // band edges move the band by one while tracking
        upperEdgeRaw = 1'b1;
        wt(2);
        rc(ADDR_PLL_STATE_FLAGS, 8'hC0, 8'hC0);
        upperEdgeRaw = 1'b0;
        wt(10);
        chk(vcoBand, band + 9'h001);
        lowerEdgeRaw = 1'b1;
        wt(2);
        rc(ADDR_PLL_STATE_FLAGS, 8'h04, 8'h04);
        lowerEdgeRaw = 1'b0;
        wt(10);
        chk(vcoBand, band);
        // recalibration restarts the search from the first band
        wr(ADDR_PLL_CONTROL, 8'h90);
        wt(20);
        chk({7'h00, pllRecal, pllEnable}, 9'h003);
        chk(vcoBand, BAND_FIRST);
        $display("test band search done");
        // lock and lost-lock events
        wr(ADDR_IRQ_ENABLE, 8'h30);
        calDoneRaw = 1'b1;
        pllLockRaw = 1'b1;
        wt(10);
        rc(ADDR_PLL_STATE_FLAGS, 8'h22, 8'h22);
        rc(ADDR_IRQ_STATUS, 8'hFF, 8'h20);
        chk({8'h00, pllIrq}, 9'h001);
        wr(ADDR_IRQ_STATUS, 8'h30);
        rc(ADDR_IRQ_STATUS, 8'hFF, 8'h00);
        chk({8'h00, pllIrq}, 9'h000);
        pllLockRaw = 1'b0;
        wt(10);
        rc(ADDR_IRQ_STATUS, 8'hFF, 8'h10);
        wr(ADDR_IRQ_STATUS, 8'h10);
        wr(ADDR_IRQ_ENABLE, 8'h00);
        pllLockRaw = 1'b1;
        wt(10);
        rc(ADDR_IRQ_STATUS, 8'hFF, 8'h00);
        chk({8'h00, pllIrq}, 9'h000);
        $display("test events done");
        // soft reset clears the configuration
        wr(ADDR_FEEDBACK_DIVIDER, 8'h55);
        softReset = 1'b1;
        wt(1);
        softReset = 1'b0;
        wt(2);
        rc(ADDR_FEEDBACK_DIVIDER, 8'hFF, 8'h00);
        chk({1'b0, feedbackLoopDivider}, 9'h000);
        $display("test soft reset done");
        finalReport();
    end
endmodule
